// >>> rtl/hpw_regs.sv
// Host port window register set: mailboxes, RAM pointer, window, boot gate
`timescale 1ns/10ps
module hpw_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_cs_n,
  input wire logic host_wr_n,
  input wire logic register_select_pin,
  input wire logic [31:0] host_data_in,
  output logic [31:0] host_data_out,
  output logic host_data_oe,
  output logic host_irq_out_pin_n,
  input wire logic host_boot_strap,
  input wire logic cpu_sel,
  input wire logic cpu_we,
  input wire logic [5:0] cpu_idx,
  input wire logic [31:0] cpu_wdata,
  output logic [31:0] cpu_rdata,
  output logic cpu_mailbox_irq,
  input wire logic cpu_ram_req,
  input wire logic cpu_ram_bank,
  input wire logic bank_mode_bit,
  input wire logic bank_select_bit,
  output logic cpu_wait,
  output logic cpu_boot_go,
  output logic ram_req,
  output logic ram_we,
  output logic [7:0] ram_addr,
  output logic [31:0] ram_wdata,
  input wire logic ram_ack,
  input wire logic [31:0] ram_rdata
);
  hpw_ram_if ram_cmd ();

  // ==========================================================
  // Pin synchroniser: two flops, then an edge history stage
  logic [35:0] sync1_q, sync2_q;
  logic cs_n_prev_q;
  logic h_cs_n, h_wr_n, h_rs, h_strap;
  logic [31:0] h_data;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 36'hF_0000_0000;
      sync2_q <= 36'hF_0000_0000;
      cs_n_prev_q <= 1'b1;
    end else begin
      sync1_q <= {host_cs_n, host_wr_n, register_select_pin, host_boot_strap, host_data_in};
      sync2_q <= sync1_q;
      cs_n_prev_q <= sync2_q[35];
    end
  end

  assign h_cs_n = sync2_q[35];
  assign h_wr_n = sync2_q[34];
  assign h_rs = sync2_q[33];
  assign h_strap = sync2_q[32];
  assign h_data = sync2_q[31:0];

  // ==========================================================
  // Host access decode: one access per chip-select falling edge
  logic h_take, h_wr, h_rd, h_idx_wr, h_reg;
  assign h_take = cs_n_prev_q && !h_cs_n;
  assign h_reg = h_take && !h_rs;
  assign h_wr = h_reg && !h_wr_n;
  assign h_rd = h_reg && h_wr_n;
  assign h_idx_wr = h_take && h_rs && !h_wr_n;

  // ==========================================================
  // Register state
  logic [5:0] idx_q, idx_d;
  logic [7:0] cirq_q, cirq_d, hirq_q, hirq_d;
  logic [7:0] ptr_q, ptr_d;
  logic [31:0] data_q, data_d;
  logic gate_q, gate_d;
  logic store_q, store_d, fetch_q, fetch_d, dir_q, dir_d, lock_q, lock_d;
  logic pend_st_q, pend_st_d, pend_ft_q, pend_ft_d;
  logic xfer_we_q, xfer_we_d;
  logic [1:0] init_q, init_d;
  logic boot_mode_q, boot_mode_d;
  logic [31:0] hout_q, hout_d, cout_q, cout_d;
  logic hoe_q, hoe_d, hint_n_q, hint_n_d, cirq_out_q, cirq_out_d;
  logic wait_q, wait_d, go_q, go_d;
  logic cpu_bank, launch;

  // Read view of a register; unused and reserved bits read zero
  function automatic logic [31:0] reg_view(input logic [5:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      hpw_pkg::IDX_CPU_IRQ: v[7:0] = cirq_q;
      hpw_pkg::IDX_HOST_IRQ: v[7:0] = hirq_q;
      hpw_pkg::IDX_PTR: v[9:2] = ptr_q;
      hpw_pkg::IDX_DATA: v = data_q;
      hpw_pkg::IDX_BOOT: v[hpw_pkg::GATE_BIT] = gate_q;
      hpw_pkg::IDX_MODE: begin
        v[hpw_pkg::LOCK_BIT] = lock_q;
        v[hpw_pkg::STORE_BIT] = store_q;
        v[hpw_pkg::FETCH_BIT] = fetch_q;
        v[hpw_pkg::DIR_BIT] = dir_q;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_view

  // CPU side of the RAM is the selected bank in bank mode, else bank 0
  assign cpu_bank = bank_mode_bit ? bank_select_bit : 1'b0;
  assign launch = !ram_cmd.busy && (pend_st_q || pend_ft_q);

  // ==========================================================
  // Next values: CPU writes first, host overrides, then RAM result, boot strap capture last
  always_comb begin
    idx_d = idx_q;
    cirq_d = cirq_q;
    hirq_d = hirq_q;
    ptr_d = ptr_q;
    data_d = data_q;
    gate_d = gate_q;
    store_d = store_q;
    fetch_d = fetch_q;
    dir_d = dir_q;
    lock_d = lock_q;
    pend_st_d = pend_st_q && !launch;
    pend_ft_d = pend_ft_q && !(launch && !pend_st_q);
    init_d = init_q;
    boot_mode_d = boot_mode_q;
    xfer_we_d = launch ? pend_st_q : xfer_we_q; // Direction of the transfer in flight
    // CPU writes: mailboxes and window only
    if (cpu_sel && cpu_we) begin
      unique case (cpu_idx)
        hpw_pkg::IDX_CPU_IRQ: cirq_d = cpu_wdata[7:0];
        hpw_pkg::IDX_HOST_IRQ: hirq_d = cpu_wdata[7:0];
        hpw_pkg::IDX_DATA: data_d = cpu_wdata;
        default: ;
      endcase
    end
    if (h_idx_wr) begin
      idx_d = h_data[5:0];
    end
    // Host writes
    if (h_wr) begin
      unique case (idx_q)
        hpw_pkg::IDX_CPU_IRQ: cirq_d = h_data[7:0];
        hpw_pkg::IDX_HOST_IRQ: hirq_d = h_data[7:0];
        hpw_pkg::IDX_PTR: ptr_d = h_data[9:2];
        hpw_pkg::IDX_DATA: begin
          data_d = h_data;
          if (lock_q && store_q) begin
            pend_st_d = 1'b1;
          end
        end
        hpw_pkg::IDX_BOOT: begin
          if (!h_data[hpw_pkg::GATE_BIT]) begin
            gate_d = 1'b0;
          end else if (h_data[7:0] == hpw_pkg::GATE_KEY) begin
            gate_d = 1'b1;
          end
        end
        hpw_pkg::IDX_MODE: begin
          lock_d = h_data[hpw_pkg::LOCK_BIT];
          store_d = h_data[hpw_pkg::STORE_BIT];
          fetch_d = h_data[hpw_pkg::FETCH_BIT];
          dir_d = h_data[hpw_pkg::DIR_BIT];
          if (h_data[hpw_pkg::STORE_BIT]) begin
            pend_st_d = 1'b1;
          end else if (h_data[hpw_pkg::FETCH_BIT]) begin
            pend_ft_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Burst read: each host read of the window fetches the next word
    if (h_rd && idx_q == hpw_pkg::IDX_DATA && lock_q && fetch_q) begin
      pend_ft_d = 1'b1;
    end
    // Transfer completion, judged by the direction latched at launch
    if (ram_cmd.done) begin
      if (!xfer_we_q) begin
        data_d = ram_cmd.rdata;
      end
      if (lock_q) begin
        ptr_d = dir_q ? ptr_q - 8'h01 : ptr_q + 8'h01;
      end else if (!(h_wr && idx_q == hpw_pkg::IDX_MODE)) begin
        // A mode write in this same cycle keeps its own command bits
        if (xfer_we_q) begin
          store_d = 1'b0;
        end else begin
          fetch_d = 1'b0;
        end
      end
    end
    // Boot strap capture: the last pass sees the pin through both sync flops
    if (init_q != 2'h0) begin
      init_d = init_q - 2'h1;
      boot_mode_d = h_strap;
      gate_d = h_strap;
    end
  end

  // ==========================================================
  // Output next values; read data from the current registers, interrupt and wait from the next state
  always_comb begin
    hout_d = hout_q;
    cout_d = cout_q;
    hoe_d = !h_cs_n && h_wr_n;
    if (h_rd) begin
      hout_d = reg_view(idx_q);
    end else if (h_take && h_rs && h_wr_n) begin
      hout_d = {26'h0, idx_q};
    end
    if (cpu_sel && !cpu_we) begin
      cout_d = reg_view(cpu_idx);
    end
    hint_n_d = !hirq_d[hpw_pkg::REQ_BIT];
    cirq_out_d = cirq_d[hpw_pkg::REQ_BIT];
    wait_d = (init_d != 2'h0) ||
             (gate_d && cpu_ram_req && cpu_ram_bank == cpu_bank);
    go_d = boot_mode_q && gate_q && !gate_d && init_q == 2'h0;
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 6'h00;
      cirq_q <= hpw_pkg::IRQ_RST;
      hirq_q <= hpw_pkg::IRQ_RST;
      ptr_q <= hpw_pkg::PTR_RST;
      data_q <= hpw_pkg::DATA_RST;
      gate_q <= 1'b0;
      store_q <= 1'b0;
      fetch_q <= 1'b0;
      dir_q <= 1'b0;
      lock_q <= 1'b0;
      pend_st_q <= 1'b0;
      pend_ft_q <= 1'b0;
      init_q <= hpw_pkg::INIT_CYCLES;
      boot_mode_q <= 1'b0;
      xfer_we_q <= 1'b0;
      hout_q <= hpw_pkg::DATA_RST;
      cout_q <= hpw_pkg::DATA_RST;
      hoe_q <= 1'b0;
      hint_n_q <= 1'b1;
      cirq_out_q <= 1'b0;
      wait_q <= 1'b1;
      go_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      cirq_q <= cirq_d;
      hirq_q <= hirq_d;
      ptr_q <= ptr_d;
      data_q <= data_d;
      gate_q <= gate_d;
      store_q <= store_d;
      fetch_q <= fetch_d;
      dir_q <= dir_d;
      lock_q <= lock_d;
      pend_st_q <= pend_st_d;
      pend_ft_q <= pend_ft_d;
      init_q <= init_d;
      boot_mode_q <= boot_mode_d;
      xfer_we_q <= xfer_we_d;
      hout_q <= hout_d;
      cout_q <= cout_d;
      hoe_q <= hoe_d;
      hint_n_q <= hint_n_d;
      cirq_out_q <= cirq_out_d;
      wait_q <= wait_d;
      go_q <= go_d;
    end
  end

  // ==========================================================
  // RAM engine command and output wiring
  assign ram_cmd.start = launch;
  assign ram_cmd.we = pend_st_q;
  assign ram_cmd.addr = ptr_q;
  assign ram_cmd.wdata = data_q;

  hpw_ram_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .cmd(ram_cmd),
    .ram_req(ram_req),
    .ram_we(ram_we),
    .ram_addr(ram_addr),
    .ram_wdata(ram_wdata),
    .ram_ack(ram_ack),
    .ram_rdata(ram_rdata)
  );

  assign host_data_out = hout_q;
  assign host_data_oe = hoe_q;
  assign host_irq_out_pin_n = hint_n_q;
  assign cpu_rdata = cout_q;
  assign cpu_mailbox_irq = cirq_out_q;
  assign cpu_wait = wait_q;
  assign cpu_boot_go = go_q;
endmodule : hpw_regs

// >>> include/hpw_pkg.sv
// Shared constants and types for the host port window registers
package hpw_pkg;
  // ==========================================================
  // Register index codes loaded into the index select field
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_CPU_IRQ = 6'h00;
  localparam logic [5:0] IDX_HOST_IRQ = 6'h01;
  localparam logic [5:0] IDX_PTR = 6'h02;
  localparam logic [5:0] IDX_DATA = 6'h03;
  localparam logic [5:0] IDX_BOOT = 6'h04;
  localparam logic [5:0] IDX_MODE = 6'h05;
  // ==========================================================
  // Field positions
  localparam int REQ_BIT = 0;
  localparam int GATE_BIT = 0;
  localparam int DIR_BIT = 0;
  localparam int FETCH_BIT = 3;
  localparam int STORE_BIT = 5;
  localparam int LOCK_BIT = 7;
  localparam int PTR_LSB = 2;
  localparam int PTR_W = 8;
  localparam int SYNC_W = 36;
  // ==========================================================
  // Reset values, key and counts
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [7:0] GATE_KEY = 8'hA5;
  localparam logic [1:0] INIT_CYCLES = 2'h3;
  // ==========================================================
  // Shared RAM transfer engine states
  typedef enum logic {ENG_IDLE, ENG_BUSY} hpw_eng_e;
endpackage : hpw_pkg

// >>> include/hpw_ram_if.sv
// Command link between the register set and the shared RAM engine
`timescale 1ns/10ps
interface hpw_ram_if;
  logic start;
  logic we;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic busy;
  logic done;
  logic [31:0] rdata;
  modport ctrl (output start, output we, output addr, output wdata,
                input busy, input done, input rdata);
  modport eng (input start, input we, input addr, input wdata,
               output busy, output done, output rdata);
endinterface : hpw_ram_if

// >>> rtl/hpw_ram_engine.sv
// Single-word shared RAM transfer engine with request/acknowledge
`timescale 1ns/10ps
module hpw_ram_engine (
  input wire logic clk,
  input wire logic rst_n,
  hpw_ram_if.eng cmd,
  output logic ram_req,
  output logic ram_we,
  output logic [7:0] ram_addr,
  output logic [31:0] ram_wdata,
  input wire logic ram_ack,
  input wire logic [31:0] ram_rdata
);
  hpw_pkg::hpw_eng_e state_q, state_d;
  logic req_q, req_d, we_q, we_d, done_q, done_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;

  // ==========================================================
  // Next state: latch a command, hold request until acknowledged
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    we_d = we_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    unique case (state_q)
      hpw_pkg::ENG_IDLE: begin
        if (cmd.start) begin
          req_d = 1'b1;
          we_d = cmd.we;
          addr_d = cmd.addr;
          wdata_d = cmd.wdata;
          state_d = hpw_pkg::ENG_BUSY;
        end
      end
      hpw_pkg::ENG_BUSY: begin
        if (ram_ack) begin
          req_d = 1'b0;
          done_d = 1'b1;
          if (!we_q) begin
            rdata_d = ram_rdata;
          end
          state_d = hpw_pkg::ENG_IDLE;
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hpw_pkg::ENG_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= hpw_pkg::PTR_RST;
      wdata_q <= hpw_pkg::DATA_RST;
      rdata_q <= hpw_pkg::DATA_RST;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  // Outputs straight from flops
  assign cmd.busy = (state_q == hpw_pkg::ENG_BUSY);
  assign cmd.done = done_q;
  assign cmd.rdata = rdata_q;
  assign ram_req = req_q;
  assign ram_we = we_q;
  assign ram_addr = addr_q;
  assign ram_wdata = wdata_q;
endmodule : hpw_ram_engine

// >>> sim/hpw_regs_properties.sv
// Port-level checks for the host port window register set
`timescale 1ns/10ps
module hpw_regs_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_cs_n,
  input wire logic host_wr_n,
  input wire logic host_data_oe,
  input wire logic host_irq_out_pin_n,
  input wire logic cpu_sel,
  input wire logic cpu_we,
  input wire logic [5:0] cpu_idx,
  input wire logic [31:0] cpu_wdata,
  input logic [31:0] cpu_rdata,
  input logic cpu_mailbox_irq,
  input wire logic cpu_ram_req,
  input wire logic cpu_ram_bank,
  input wire logic bank_mode_bit,
  input wire logic bank_select_bit,
  input logic cpu_wait,
  input logic cpu_boot_go,
  input logic ram_req,
  input logic ram_we,
  input logic [7:0] ram_addr,
  input logic [31:0] ram_wdata,
  input wire logic ram_ack
);
  // ==========================================
  // Cycles since reset release, saturating at three
  logic [1:0] up_q;
  logic [1:0] up_d;
  always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_q <= 2'h0;
    else up_q <= up_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Interrupt outputs follow the request bits written by the CPU
  a_cpu_irq_follow: assert property (cpu_sel && cpu_we && cpu_idx == hpw_pkg::IDX_CPU_IRQ
    |=> cpu_mailbox_irq == $past(cpu_wdata[0])) else $error("cpu irq wrong");
  a_host_pin_follow: assert property (cpu_sel && cpu_we && cpu_idx == hpw_pkg::IDX_HOST_IRQ
    |=> host_irq_out_pin_n == !$past(cpu_wdata[0])) else $error("host irq pin wrong");
  // Reserved bits read as zero
  a_irq_rsvd_zero: assert property (cpu_sel && !cpu_we && cpu_idx <= hpw_pkg::IDX_HOST_IRQ
    |=> cpu_rdata[31:8] == 24'h000000) else $error("irq reserved bits set");
  a_ptr_rsvd_zero: assert property (cpu_sel && !cpu_we && cpu_idx == hpw_pkg::IDX_PTR
    |=> cpu_rdata[31:10] == 22'h000000 && cpu_rdata[1:0] == 2'h0) else $error("ptr bits set");
  a_gate_rsvd_zero: assert property (cpu_sel && !cpu_we && cpu_idx == hpw_pkg::IDX_BOOT
    |=> cpu_rdata[31:1] == 31'h00000000) else $error("boot reserved bits set");
  // RAM request held steady until acknowledged, then dropped
  a_ram_req_hold: assert property (ram_req && !ram_ack
    |=> ram_req && $stable(ram_addr) && $stable(ram_we) && $stable(ram_wdata))
    else $error("ram request moved");
  a_ram_req_drop: assert property (ram_req && ram_ack |=> !ram_req)
    else $error("ram request not dropped");
  a_oe_idle: assert property (host_cs_n [*4] |=> !host_data_oe)
    else $error("data driven while deselected");
  a_oe_read: assert property ($fell(host_cs_n) && host_wr_n
    ##1 (!host_cs_n && host_wr_n) [*4] |=> host_data_oe)
    else $error("read data not driven");
  a_boot_go_pulse: assert property (cpu_boot_go |=> !cpu_boot_go)
    else $error("boot pulse too long");
  a_no_stall_idle: assert property (up_q == 2'h3 && (!cpu_ram_req ||
    cpu_ram_bank != (bank_mode_bit ? bank_select_bit : 1'b0)) |=> !cpu_wait)
    else $error("cpu stalled without cause");
endmodule : hpw_regs_properties

bind hpw_regs hpw_regs_properties u_props (.*);

// >>> sim/hpw_host_model.sv
// Behavioural host processor on the parallel host bus
`timescale 1ns/10ps
module hpw_host_model (
  input wire logic clk,
  input wire logic [31:0] host_data_out,
  output logic host_cs_n,
  output logic host_wr_n,
  output logic register_select_pin,
  output logic [31:0] host_data_in
);
  // ==========================================
  // Idle bus: deselected, data lines show the inverse of the last word
  initial begin
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    register_select_pin = 1'b1;
    host_data_in = 32'h0000_0000;
  end
  // One access, held well past the synchroniser lag
  task automatic cyc(input logic rs, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    host_cs_n <= 1'b0;
    host_wr_n <= !wr;
    register_select_pin <= rs;
    host_data_in <= d;
    repeat (6) @(posedge clk);
    q = host_data_out;
    host_cs_n <= 1'b1;
    host_wr_n <= 1'b1;
    host_data_in <= ~d;
    repeat (5) @(posedge clk);
  endtask : cyc
  // Index first with select high, then the register with select low
  task automatic wr_reg(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    cyc(1'b1, 1'b1, {26'h0, idx}, q);
    cyc(1'b0, 1'b1, d, q);
  endtask : wr_reg
  task automatic rd_reg(input logic [5:0] idx, output logic [31:0] q);
    cyc(1'b1, 1'b1, {26'h0, idx}, q);
    cyc(1'b0, 1'b0, 32'h0000_0000, q);
  endtask : rd_reg
endmodule : hpw_host_model

// >>> sim/testbench.sv
// Self-checking bench for the host port window register set
`timescale 1ns/10ps
module testbench;
  logic clk, rst_n, host_boot_strap, cpu_sel, cpu_we, cpu_ram_req, cpu_ram_bank;
  logic bank_mode_bit, bank_select_bit, ram_ack, host_cs_n, host_wr_n;
  logic register_select_pin, host_data_oe, host_irq_out_pin_n, cpu_mailbox_irq;
  logic cpu_wait, cpu_boot_go, ram_req, ram_we, go_seen, req_seen;
  logic [1:0] wt;
  logic [5:0] cpu_idx;
  logic [7:0] ram_addr;
  logic [31:0] host_data_in, host_data_out, cpu_wdata, cpu_rdata, ram_wdata, ram_rdata, q;
  logic [31:0] mem [0:255];
  int failures, compares;
  hpw_regs dut (.*);
  hpw_host_model h (.*);
  // ==========================================
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Shared RAM: answers after a short stall, read lines inverted when idle
  always @(posedge clk) begin
    ram_ack <= 1'b0;
    ram_rdata <= ~ram_rdata;
    wt <= (ram_req && !ram_ack) ? wt + 2'h1 : 2'h0;
    if (ram_req && !ram_ack && wt == 2'h2) begin
      ram_ack <= 1'b1;
      ram_rdata <= mem[ram_addr];
      if (ram_we) mem[ram_addr] <= ram_wdata;
    end
    if (ram_req) req_seen <= 1'b1;
    if (cpu_boot_go) go_seen <= 1'b1;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One CPU register access; read data lands in q
  task automatic cpu(input logic w, input logic [5:0] i, input logic [31:0] d);
    @(posedge clk);
    cpu_sel <= 1'b1;
    cpu_we <= w;
    cpu_idx <= i;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_sel <= 1'b0;
    #1 q = cpu_rdata;
  endtask : cpu
  // Host write, then room for any RAM transfer to finish
  task automatic hw(input logic [5:0] i, input logic [31:0] d);
    h.wr_reg(i, d);
    repeat (10) @(posedge clk);
  endtask : hw
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    host_boot_strap <= s;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : do_reset
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      cpu(1'b0, 6'(i), 32'h0);
      chk("reset value", q, 32'h0);
    end
    chk("host pin", {31'h0, host_irq_out_pin_n}, 32'h1);
  endtask : t_reset
  task automatic t_irq;
    hw(hpw_pkg::IDX_CPU_IRQ, 32'hFFFF_FFFF);
    chk("cpu irq", {31'h0, cpu_mailbox_irq}, 32'h1);
    cpu(1'b0, hpw_pkg::IDX_CPU_IRQ, 32'h0);
    chk("cpu irq reg", q, 32'h0000_00FF);
    cpu(1'b1, hpw_pkg::IDX_CPU_IRQ, 32'h0000_00FE);
    chk("cpu irq", {31'h0, cpu_mailbox_irq}, 32'h0);
    cpu(1'b1, hpw_pkg::IDX_HOST_IRQ, 32'h0000_0081);
    chk("host pin", {31'h0, host_irq_out_pin_n}, 32'h0);
    h.rd_reg(hpw_pkg::IDX_HOST_IRQ, q);
    chk("host irq reg", q, 32'h0000_0081);
    h.cyc(1'b1, 1'b0, 32'h0000_0000, q);
    chk("index read", q, {26'h0, hpw_pkg::IDX_HOST_IRQ});
    hw(hpw_pkg::IDX_HOST_IRQ, 32'h0000_0080);
    chk("host pin", {31'h0, host_irq_out_pin_n}, 32'h1);
  endtask : t_irq
  task automatic t_ptr;
    hw(hpw_pkg::IDX_PTR, 32'hFFFF_FFFF);
    cpu(1'b1, hpw_pkg::IDX_PTR, 32'h0);
    cpu(1'b0, hpw_pkg::IDX_PTR, 32'h0);
    chk("pointer", q, 32'h0000_03FC);
  endtask : t_ptr
  task automatic t_mailbox;
    req_seen = 1'b0;
    cpu(1'b1, hpw_pkg::IDX_DATA, 32'h1234_5678);
    h.rd_reg(hpw_pkg::IDX_DATA, q);
    chk("window to host", q, 32'h1234_5678);
    hw(hpw_pkg::IDX_DATA, 32'hCAFE_F00D);
    cpu(1'b0, hpw_pkg::IDX_DATA, 32'h0);
    chk("window to cpu", q, 32'hCAFE_F00D);
    chk("ram idle", {31'h0, req_seen}, 32'h0);
  endtask : t_mailbox
  task automatic t_single;
    hw(hpw_pkg::IDX_PTR, 32'h0000_0010);
    hw(hpw_pkg::IDX_DATA, 32'hA1B2_C3D4);
    hw(hpw_pkg::IDX_MODE, 32'h0000_0020);
    chk("stored word", mem[4], 32'hA1B2_C3D4);
    cpu(1'b0, hpw_pkg::IDX_MODE, 32'h0);
    chk("store cleared", q & 32'h0000_0020, 32'h0);
    mem[5] = 32'h5566_7788;
    hw(hpw_pkg::IDX_PTR, 32'h0000_0014);
    hw(hpw_pkg::IDX_MODE, 32'h0000_0009);
    cpu(1'b0, hpw_pkg::IDX_DATA, 32'h0);
    chk("fetched word", q, 32'h5566_7788);
    cpu(1'b0, hpw_pkg::IDX_PTR, 32'h0);
    chk("pointer held", q, 32'h0000_0014);
  endtask : t_single
  task automatic t_burst;
    hw(hpw_pkg::IDX_PTR, 32'h0000_0020);
    hw(hpw_pkg::IDX_DATA, 32'h0000_1111);
    hw(hpw_pkg::IDX_MODE, 32'h0000_00A0);
    hw(hpw_pkg::IDX_DATA, 32'h0000_2222);
    chk("burst word 0", mem[8], 32'h0000_1111);
    chk("burst word 1", mem[9], 32'h0000_2222);
    cpu(1'b0, hpw_pkg::IDX_PTR, 32'h0);
    chk("pointer up", q, 32'h0000_0028);
    hw(hpw_pkg::IDX_MODE, 32'h0000_0000);
    hw(hpw_pkg::IDX_DATA, 32'h0000_3333);
    hw(hpw_pkg::IDX_MODE, 32'h0000_00A1);
    chk("burst down", mem[10], 32'h0000_3333);
    cpu(1'b0, hpw_pkg::IDX_PTR, 32'h0);
    chk("pointer down", q, 32'h0000_0024);
    mem[10] = 32'h0000_4444;
    hw(hpw_pkg::IDX_MODE, 32'h0000_0088);
    h.rd_reg(hpw_pkg::IDX_DATA, q);
    chk("burst fetch 0", q, 32'h0000_2222);
    cpu(1'b0, hpw_pkg::IDX_DATA, 32'h0);
    chk("burst fetch 1", q, 32'h0000_4444);
    cpu(1'b0, hpw_pkg::IDX_PTR, 32'h0);
    chk("pointer fetch up", q, 32'h0000_002C);
    hw(hpw_pkg::IDX_MODE, 32'h0000_0000);
  endtask : t_burst
  task automatic t_boot;
    do_reset(1'b1);
    cpu(1'b0, hpw_pkg::IDX_BOOT, 32'h0);
    chk("gate at boot", q, 32'h1);
    @(posedge clk);
    cpu_ram_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("cpu stalled", {31'h0, cpu_wait}, 32'h1);
    cpu(1'b1, hpw_pkg::IDX_BOOT, 32'h0);
    cpu(1'b0, hpw_pkg::IDX_BOOT, 32'h0);
    chk("cpu write", q, 32'h1);
    go_seen = 1'b0;
    hw(hpw_pkg::IDX_BOOT, 32'h0);
    chk("boot release", {31'h0, go_seen}, 32'h1);
    chk("cpu free", {31'h0, cpu_wait}, 32'h0);
    hw(hpw_pkg::IDX_BOOT, 32'h0000_0001);
    cpu(1'b0, hpw_pkg::IDX_BOOT, 32'h0);
    chk("gate no key", q, 32'h0);
    hw(hpw_pkg::IDX_BOOT, 32'h0000_00A5);
    cpu(1'b0, hpw_pkg::IDX_BOOT, 32'h0);
    chk("gate keyed", q, 32'h1);
    @(posedge clk);
    cpu_ram_bank <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("other bank", {31'h0, cpu_wait}, 32'h0);
    @(posedge clk);
    bank_mode_bit <= 1'b1;
    bank_select_bit <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("cpu bank", {31'h0, cpu_wait}, 32'h1);
  endtask : t_boot
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    {rst_n, host_boot_strap, cpu_sel, cpu_we, cpu_ram_req, cpu_ram_bank} = 6'h00;
    {bank_mode_bit, bank_select_bit, ram_ack, go_seen, req_seen, wt} = 7'h00;
    {cpu_idx, cpu_wdata, ram_rdata} = 70'h0;
    failures = 0;
    compares = 0;
    do_reset(1'b0);
    t_reset;
    t_irq;
    t_ptr;
    t_mailbox;
    t_single;
    t_burst;
    t_boot;
    stop_test;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test;
  end
endmodule : testbench
